// *** core/sfpx_consts.svh ***
`ifndef SFPX_CONSTS_SVH
`define SFPX_CONSTS_SVH

// Register byte offsets
`define SFPX_OFF_CSR       32'h00000000
`define SFPX_OFF_IRQ_STS   32'h00000004
`define SFPX_OFF_IRQ_EN    32'h00000008
`define SFPX_OFF_EXC_INFO  32'h0000000C

// Field positions
`define SFPX_CSR_FLAG_LSB  0
`define SFPX_CSR_MASK_LSB  8
`define SFPX_INFO_FAULT    4
`define SFPX_INFO_TRAP     5
`define SFPX_INFO_OP_LSB   8
`define SFPX_IRQ_FAULT     0
`define SFPX_IRQ_TRAP      1

// Reset values
`define SFPX_MASK_RST      6'h3F
`define SFPX_IRQ_EN_RST    2'h0

// Special encodings
`define SFPX_QNAN_SP       32'hFFC00000
`define SFPX_QNAN_DP       64'hFFF8000000000000
`define SFPX_INT_INDEF     32'h80000000
`define SFPX_QUIET_SP      32'h00400000
`define SFPX_QUIET_DP      64'h0008000000000000

`endif

// *** core/sfpx_pkg.sv ***
package sfpx_pkg;

    typedef enum logic [2:0] {
        SFPX_OP_ADD  = 3'h0,
        SFPX_OP_SUB  = 3'h1,
        SFPX_OP_MUL  = 3'h2,
        SFPX_OP_DIV  = 3'h3,
        SFPX_OP_SQRT = 3'h4,
        SFPX_OP_CVTI = 3'h5
    } sfpx_op_e;

    // Flag vectors: bit 0 invalid, 1 divide-by-zero, 2 denormal, 3 overflow, 4 underflow, 5 inexact
    typedef struct packed {
        logic             valid;
        sfpx_op_e         op;
        logic             dbl;
        logic             packed_op;
        logic [127:0]     src1;
        logic [127:0]     src2;
        logic [127:0]     arith;
        logic [3:0][2:0]  post;
        logic [3:0]       cvt_rng;
    } sfpx_req_s;

    typedef struct packed {
        logic             res_valid;
        logic [127:0]     res;
        logic             exc_valid;
        logic             fault;
        logic             trap;
        logic [5:0]       flags;
        logic [127:0]     src1;
        logic [127:0]     src2;
    } sfpx_rsp_s;

    typedef struct packed {
        logic             psel;
        logic             penable;
        logic             pwrite;
        logic [31:0]      paddr;
        logic [31:0]      pwdata;
    } sfpx_apb_req_s;

    typedef struct packed {
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
    } sfpx_apb_rsp_s;

    typedef struct packed {
        logic [5:0]       flags;
        logic [5:0]       mask;
        logic [1:0]       irq_sts;
        logic [1:0]       irq_en;
        logic [3:0]       exc_lanes;
        sfpx_op_e         exc_op;
        logic [31:0]      prdata;
        sfpx_rsp_s        rsp;
    } sfpx_state_s;

endpackage

// *** core/sfpx_classify.sv ***
`timescale 1ns/1ps
`default_nettype none

module sfpx_classify (
    // Operation
    input  wire sfpx_pkg::sfpx_op_e op_in,
    input  wire logic               dbl_in,
    input  wire logic [63:0]        a_in,
    input  wire logic [63:0]        b_in,
    input  wire logic               rng_err_in,
    // Classification
    output logic                    a_nan_out,
    output logic                    a_snan_out,
    output logic                    b_nan_out,
    output logic                    b_snan_out,
    output logic [2:0]              pre_out
);
    import sfpx_pkg::*;

    // Returns {sign, nan, snan, inf, zero, denormal}
    function automatic logic [5:0] cls(input logic [63:0] v, input logic dbl);
        logic emax;
        logic ezero;
        logic fnz;
        logic qb;
        logic sg;
        emax  = dbl ? &v[62:52] : &v[30:23];
        ezero = dbl ? ~|v[62:52] : ~|v[30:23];
        fnz   = dbl ? |v[51:0] : |v[22:0];
        qb    = dbl ? v[51] : v[22];
        sg    = dbl ? v[63] : v[31];
        cls   = {sg, emax & fnz, emax & fnz & ~qb, emax & ~fnz, ezero & ~fnz, ezero & fnz};
    endfunction

    logic [5:0] ca;
    logic [5:0] cb;
    logic       two_op;
    logic       nan_in;
    logic       spec;

    always_comb begin
        two_op = (op_in == SFPX_OP_ADD) || (op_in == SFPX_OP_SUB) ||
                 (op_in == SFPX_OP_MUL) || (op_in == SFPX_OP_DIV);
        ca = cls(a_in, dbl_in);
        cb = two_op ? cls(b_in, dbl_in) : 6'h00;
        a_nan_out  = ca[4];
        a_snan_out = ca[3];
        b_nan_out  = cb[4];
        b_snan_out = cb[3];
        nan_in = ca[4] | cb[4];
        // Infinity and zero classes exclude NaNs, so these are the no-NaN invalid cases, except CVTI, which also counts any NaN input
        unique case (op_in)
            SFPX_OP_ADD:  spec = ca[2] & cb[2] & (ca[5] ^ cb[5]);
            SFPX_OP_SUB:  spec = ca[2] & cb[2] & ~(ca[5] ^ cb[5]);
            SFPX_OP_MUL:  spec = (ca[2] & cb[1]) | (ca[1] & cb[2]);
            SFPX_OP_DIV:  spec = (ca[2] & cb[2]) | (ca[1] & cb[1]);
            SFPX_OP_SQRT: spec = ca[5] & ~ca[1] & ~nan_in;
            SFPX_OP_CVTI: spec = nan_in | rng_err_in;
            default:      spec = 1'b0;
        endcase
        pre_out[0] = ca[3] | cb[3] | spec;
        pre_out[1] = (op_in == SFPX_OP_DIV) & cb[1] & ~(ca[1] | ca[2] | ca[4]);
        pre_out[2] = ~nan_in & (op_in != SFPX_OP_CVTI) & (ca[0] | cb[0]);
    end

endmodule

`default_nettype wire

// *** core/sfpx_nan_pick.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sfpx_consts.svh"

module sfpx_nan_pick (
    // Lane context
    input  wire logic        dbl_in,
    input  wire logic        cvt_in,
    input  wire logic        a_nan_in,
    input  wire logic        b_nan_in,
    input  wire logic [63:0] a_in,
    input  wire logic [63:0] b_in,
    // Replacement value
    output logic [63:0]      nan_out
);
    import sfpx_pkg::*;

    logic [63:0] quiet;

    always_comb begin
        quiet = dbl_in ? `SFPX_QUIET_DP : {32'h00000000, `SFPX_QUIET_SP};
        if (cvt_in) begin
            nan_out = {32'h00000000, `SFPX_INT_INDEF};
        end else if (a_nan_in) begin
            nan_out = a_in | quiet;
        end else if (b_nan_in) begin
            nan_out = b_in | quiet;
        end else if (dbl_in) begin
            nan_out = `SFPX_QNAN_DP;
        end else begin
            nan_out = {32'h00000000, `SFPX_QNAN_SP};
        end
    end

endmodule

`default_nettype wire

// *** core/sfpx_unit.sv ***
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sfpx_consts.svh"

module sfpx_unit (
    // Clock and reset
    input  wire logic                    CLK_IN,
    input  wire logic                    RST_N_IN,
    // Operation from pipeline
    input  wire sfpx_pkg::sfpx_req_s     OP_IN,
    output var  sfpx_pkg::sfpx_rsp_s     RSP_OUT,
    // APB slave
    input  wire sfpx_pkg::sfpx_apb_req_s APB_IN,
    output var  sfpx_pkg::sfpx_apb_rsp_s APB_OUT,
    // Interrupt
    output logic                         IRQ_OUT
);
    import sfpx_pkg::*;

    sfpx_state_s      st_q;
    sfpx_state_s      st_d;
    logic [3:0]       lane_act;
    logic [3:0][2:0]  lane_pre;
    logic [3:0][2:0]  lane_post;
    logic [3:0]       lane_ovr;
    logic [3:0][63:0] lane_res;
    logic [3:0]       lane_snan;
    logic [3:0]       lane_qonly;
    logic [3:0]       lane_unm_f;
    logic [3:0]       lane_unm_t;
    logic [2:0]       pre_or;
    logic [2:0]       post_or;
    logic             fault_take;
    logic             trap_take;
    logic [5:0]       evt_flags;
    logic [127:0]     res_asm;
    logic             apb_setup;
    logic             apb_access;
    logic             hit_csr;
    logic             hit_sts;
    logic             hit_en;
    logic             hit_info;
    logic             apb_mapped;
    logic             apb_wr;
    logic [31:0]      rd_mux;

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    // Per element classification and NaN selection
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            localparam int DW = gi % 2;
            logic [63:0] a;
            logic [63:0] b;
            logic [63:0] r;
            logic [63:0] pick;
            logic        a_nan;
            logic        a_snan;
            logic        b_nan;
            logic        b_snan;
            logic        cvt;

            always_comb begin
                cvt = OP_IN.op == SFPX_OP_CVTI;
                if (OP_IN.dbl) begin
                    a = OP_IN.src1[64*DW +: 64];
                    b = OP_IN.src2[64*DW +: 64];
                    r = OP_IN.arith[64*DW +: 64];
                end else begin
                    a = {32'h00000000, OP_IN.src1[32*gi +: 32]};
                    b = {32'h00000000, OP_IN.src2[32*gi +: 32]};
                    r = {32'h00000000, OP_IN.arith[32*gi +: 32]};
                end
            end

            sfpx_classify u_cls (
                .op_in      (OP_IN.op),
                .dbl_in     (OP_IN.dbl),
                .a_in       (a),
                .b_in       (b),
                .rng_err_in (OP_IN.cvt_rng[gi]),
                .a_nan_out  (a_nan),
                .a_snan_out (a_snan),
                .b_nan_out  (b_nan),
                .b_snan_out (b_snan),
                .pre_out    (lane_pre[gi])
            );

            sfpx_nan_pick u_pick (
                .dbl_in   (OP_IN.dbl),
                .cvt_in   (cvt),
                .a_nan_in (a_nan),
                .b_nan_in (b_nan),
                .a_in     (a),
                .b_in     (b),
                .nan_out  (pick)
            );

            // A NaN or invalid element never reaches rounding, so its trap flags are dropped
            assign lane_ovr[gi]   = a_nan | b_nan | lane_pre[gi][0];
            assign lane_post[gi]  = lane_ovr[gi] ? 3'h0 : OP_IN.post[gi];
            assign lane_res[gi]   = lane_ovr[gi] ? pick : r;
            assign lane_snan[gi]  = a_snan | b_snan;
            assign lane_qonly[gi] = (a_nan | b_nan) & ~lane_snan[gi] & ~cvt;

            a_snan_invalid: assert property (
                lane_snan[gi] |-> lane_pre[gi][0])
                else $error("signaling NaN input did not raise invalid");

            a_qnan_passive: assert property (
                lane_qonly[gi] |-> !lane_pre[gi][0] && lane_post[gi] == 3'h0 &&
                                   lane_res[gi] == (a_nan ? a : b))
                else $error("quiet NaN input raised a flag or lost its value");

            a_first_nan: assert property (
                (a_nan && !cvt) |-> lane_res[gi] ==
                    (a | (OP_IN.dbl ? `SFPX_QUIET_DP : {32'h00000000, `SFPX_QUIET_SP})))
                else $error("first NaN operand not selected and quieted");

            a_qnan_single: assert property (
                (lane_pre[gi][0] && !a_nan && !b_nan && !cvt && !OP_IN.dbl)
                    |-> lane_res[gi][31:0] == `SFPX_QNAN_SP)
                else $error("single invalid result is not QNaN indefinite");

            a_qnan_double: assert property (
                (lane_pre[gi][0] && !a_nan && !b_nan && !cvt && OP_IN.dbl)
                    |-> lane_res[gi] == `SFPX_QNAN_DP)
                else $error("double invalid result is not QNaN indefinite");

            a_int_indef: assert property (
                (cvt && lane_pre[gi][0]) |-> lane_res[gi][31:0] == `SFPX_INT_INDEF)
                else $error("invalid conversion did not give integer indefinite");
        end
    endgenerate

    // Merge elements and classify the operation
    always_comb begin
        if (!OP_IN.packed_op) begin
            lane_act = 4'h1;
        end else if (OP_IN.dbl) begin
            lane_act = 4'h3;
        end else begin
            lane_act = 4'hF;
        end
        pre_or     = 3'h0;
        post_or    = 3'h0;
        lane_unm_f = 4'h0;
        lane_unm_t = 4'h0;
        for (int i = 0; i < 4; i++) begin
            if (lane_act[i]) begin
                pre_or        = pre_or | lane_pre[i];
                post_or       = post_or | lane_post[i];
                lane_unm_f[i] = |(lane_pre[i] & ~st_q.mask[2:0]);
                lane_unm_t[i] = |(lane_post[i] & ~st_q.mask[5:3]);
            end
        end
        fault_take = OP_IN.valid & |(pre_or & ~st_q.mask[2:0]);
        // An unmasked fault stops the computation, so no trap can follow it
        trap_take = OP_IN.valid & ~fault_take & |(post_or & ~st_q.mask[5:3]);
        if (!OP_IN.valid) begin
            evt_flags = 6'h00;
        end else if (fault_take) begin
            evt_flags = {3'h0, pre_or};
        end else begin
            evt_flags = {post_or, pre_or};
        end
    end

    // Scalar forms pass the upper part of the first source through
    always_comb begin
        if (OP_IN.dbl) begin
            if (OP_IN.packed_op) begin
                res_asm = {lane_res[1], lane_res[0]};
            end else begin
                res_asm = {OP_IN.src1[127:64], lane_res[0]};
            end
        end else if (OP_IN.packed_op) begin
            res_asm = {lane_res[3][31:0], lane_res[2][31:0], lane_res[1][31:0], lane_res[0][31:0]};
        end else begin
            res_asm = {OP_IN.src1[127:32], lane_res[0][31:0]};
        end
    end

    // APB decode; zero wait states, read data captured in the setup cycle
    always_comb begin
        apb_setup  = APB_IN.psel & ~APB_IN.penable;
        apb_access = APB_IN.psel & APB_IN.penable;
        hit_csr    = APB_IN.paddr == `SFPX_OFF_CSR;
        hit_sts    = APB_IN.paddr == `SFPX_OFF_IRQ_STS;
        hit_en     = APB_IN.paddr == `SFPX_OFF_IRQ_EN;
        hit_info   = APB_IN.paddr == `SFPX_OFF_EXC_INFO;
        apb_mapped = hit_csr | hit_sts | hit_en | hit_info;
        apb_wr     = apb_access & APB_IN.pwrite & apb_mapped;
        rd_mux     = 32'h00000000;
        if (hit_csr) begin
            rd_mux[`SFPX_CSR_FLAG_LSB +: 6] = st_q.flags;
            rd_mux[`SFPX_CSR_MASK_LSB +: 6] = st_q.mask;
        end else if (hit_sts) begin
            rd_mux[1:0] = st_q.irq_sts;
        end else if (hit_en) begin
            rd_mux[1:0] = st_q.irq_en;
        end else if (hit_info) begin
            rd_mux[3:0]                    = st_q.exc_lanes;
            rd_mux[`SFPX_INFO_FAULT]       = st_q.rsp.fault;
            rd_mux[`SFPX_INFO_TRAP]        = st_q.rsp.trap;
            rd_mux[`SFPX_INFO_OP_LSB +: 3] = st_q.exc_op;
        end
        APB_OUT.prdata  = st_q.prdata;
        APB_OUT.pready  = 1'b1;
        APB_OUT.pslverr = apb_access & ~apb_mapped;
        RSP_OUT         = st_q.rsp;
        IRQ_OUT         = |(st_q.irq_sts & st_q.irq_en);
    end

    // Next state
    always_comb begin
        st_d               = st_q;
        st_d.rsp.res_valid = 1'b0;
        st_d.rsp.exc_valid = 1'b0;
        if (apb_setup) begin
            st_d.prdata = rd_mux;
        end
        if (OP_IN.valid) begin
            st_d.rsp.fault     = fault_take;
            st_d.rsp.trap      = trap_take;
            st_d.rsp.flags     = evt_flags;
            st_d.rsp.exc_valid = fault_take | trap_take;
            if (fault_take | trap_take) begin
                // Handler gets the untouched operands instead of a result
                st_d.rsp.src1  = OP_IN.src1;
                st_d.rsp.src2  = OP_IN.src2;
                st_d.exc_lanes = fault_take ? lane_unm_f : lane_unm_t;
                st_d.exc_op    = OP_IN.op;
            end else begin
                st_d.rsp.res_valid = 1'b1;
                st_d.rsp.res       = res_asm;
            end
        end
        // Clears first so that a same-cycle event is kept
        if (apb_wr && hit_csr) begin
            st_d.flags = st_q.flags & ~APB_IN.pwdata[`SFPX_CSR_FLAG_LSB +: 6];
            st_d.mask  = APB_IN.pwdata[`SFPX_CSR_MASK_LSB +: 6];
        end
        if (apb_wr && hit_sts) begin
            st_d.irq_sts = st_q.irq_sts & ~APB_IN.pwdata[1:0];
        end
        if (apb_wr && hit_en) begin
            st_d.irq_en = APB_IN.pwdata[1:0];
        end
        st_d.flags                   = st_d.flags | evt_flags;
        st_d.irq_sts[`SFPX_IRQ_FAULT] = st_d.irq_sts[`SFPX_IRQ_FAULT] | fault_take;
        st_d.irq_sts[`SFPX_IRQ_TRAP]  = st_d.irq_sts[`SFPX_IRQ_TRAP] | trap_take;
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            st_q        <= '0;
            st_q.mask   <= `SFPX_MASK_RST;
            st_q.irq_en <= `SFPX_IRQ_EN_RST;
        end else begin
            st_q <= st_d;
        end
    end

    sequence s_op_fault;
        OP_IN.valid && |(pre_or & ~st_q.mask[2:0]);
    endsequence

    sequence s_op_trap;
        OP_IN.valid && !(|(pre_or & ~st_q.mask[2:0])) && |(post_or & ~st_q.mask[5:3]);
    endsequence

    sequence s_op_clean;
        OP_IN.valid && !(|(pre_or & ~st_q.mask[2:0])) && !(|(post_or & ~st_q.mask[5:3]));
    endsequence

    a_flags_sticky: assert property (
        ((st_q.flags & $past(evt_flags)) == $past(evt_flags)) &&
        ((st_q.flags & ~$past(st_q.flags)) == ($past(evt_flags) & ~$past(st_q.flags))))
        else $error("status flag not set by its event or set without one");

    a_fault_first: assert property (
        s_op_fault |=> RSP_OUT.exc_valid && RSP_OUT.fault && !RSP_OUT.trap &&
                       RSP_OUT.flags[5:3] == 3'h0 && RSP_OUT.flags[2:0] == $past(pre_or))
        else $error("unmasked pre-computation condition not reported as fault");

    a_trap_after: assert property (
        s_op_trap |=> RSP_OUT.exc_valid && RSP_OUT.trap && !RSP_OUT.fault &&
                      RSP_OUT.flags[5:3] == $past(post_or))
        else $error("unmasked post-computation condition not reported as trap");

    a_masked_result: assert property (
        s_op_clean |=> RSP_OUT.res_valid && !RSP_OUT.exc_valid && RSP_OUT.res == $past(res_asm))
        else $error("masked operation did not deliver its result");

    a_no_result_held: assert property (
        (s_op_fault or s_op_trap) |=> !RSP_OUT.res_valid &&
            RSP_OUT.src1 == $past(OP_IN.src1) && RSP_OUT.src2 == $past(OP_IN.src2)
            ##1 (RSP_OUT.exc_valid || $stable(RSP_OUT.src1)))
        else $error("unmasked exception delivered a result or lost operands");

    a_packed_or: assert property (
        (OP_IN.valid && OP_IN.packed_op && !OP_IN.dbl) |=>
            RSP_OUT.flags[2:0] == $past(lane_pre[0] | lane_pre[1] | lane_pre[2] | lane_pre[3]))
        else $error("packed flags are not the OR of the elements");

    a_flag_set_wins: assert property (
        (apb_wr && hit_csr && APB_IN.pwdata[0] && evt_flags[0]) |=> st_q.flags[0])
        else $error("event lost to a same-cycle clear");

    a_irq_level: assert property (
        (OP_IN.valid && |(pre_or & ~st_q.mask[2:0]) && st_q.irq_en[`SFPX_IRQ_FAULT])
            |=> IRQ_OUT)
        else $error("unmasked fault did not raise the interrupt");

endmodule

`default_nettype wire

// *** test/sfpx_pipe_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module sfpx_pipe_model (
    // Clock
    input  wire logic               clk_in,
    // Issue port
    output var  sfpx_pkg::sfpx_req_s op_out
);
    import sfpx_pkg::*;

    initial op_out = '0;

    // One op per call; operand lines go stale-inverted once valid drops
    // Raw result stand-in is a ^ b, so each element's routing shows
    task automatic send(input sfpx_op_e o, input logic d, pk, input logic [127:0] a, b,
                        input logic [11:0] post, input logic [3:0] rng);
        @(posedge clk_in);
        op_out <= '{1'h1, o, d, pk, a, b, a ^ b, post, rng};
        @(posedge clk_in);
        op_out <= {1'h0, ~op_out[$bits(op_out)-2:0]};
        #1;
    endtask
endmodule

`default_nettype wire

// *** test/sfpx_unit_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sfpx_consts.svh"

module sfpx_unit_test;
    import sfpx_pkg::*;
    logic          clk;
    logic          rst_n;
    sfpx_req_s     op;
    sfpx_rsp_s     rsp;
    sfpx_apb_req_s apb_q;
    sfpx_apb_rsp_s apb_r;
    logic          irq;
    logic [31:0]   rd;
    logic          err;
    logic [127:0]  last;
    int            error_cnt;
    int            samples_checked;

    sfpx_unit sfpx_unit_i (.CLK_IN(clk), .RST_N_IN(rst_n), .OP_IN(op), .RSP_OUT(rsp),
                           .APB_IN(apb_q), .APB_OUT(apb_r), .IRQ_OUT(irq));
    sfpx_pipe_model sfpx_pipe_model_i (.clk_in(clk), .op_out(op));

    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    task automatic test_done();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        apb_q <= '{1'h1, 1'h0, w, a, d};
        @(posedge clk);
        apb_q.penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (apb_r.pready !== 1'h1 && n < 16);
        if (n >= 16) begin
            error_cnt++;
            test_done();
        end
        rd = apb_r.prdata;
        err = apb_r.pslverr;
        apb_q <= '0;
    endtask

    // Masked op: one result pulse, value and per-op flags
    task automatic run(input sfpx_op_e o, input logic d, pk, input logic [127:0] a, b,
                       input logic [11:0] post, input logic [127:0] exp, input logic [5:0] fl);
        sfpx_pipe_model_i.send(o, d, pk, a, b, post, 4'h0);
        chk({rsp.res_valid, rsp.exc_valid}, 2'h2);
        chk(rsp.res, exp);
        chk(rsp.flags, fl);
    endtask

    task automatic t_reset();
        apb(1'h0, `SFPX_OFF_CSR, 32'h0);
        chk(rd, 32'h00003F00);
        apb(1'h0, 32'h00000010, 32'h0);
        chk({rd, err}, 33'h1);
    endtask

    task automatic t_masked();
        run(SFPX_OP_ADD, 1'h0, 1'h0, 128'h7FC00001, 128'h3F800000, 12'h0, 128'h7FC00001, 6'h0);
        run(SFPX_OP_ADD, 1'h0, 1'h0, 128'h7FC00001, 128'h7FC00002, 12'h001, 128'h7FC00001, 6'h0);
        run(SFPX_OP_SUB, 1'h0, 1'h0, 128'h7F800001, 128'h7FC00002, 12'h0, 128'h7FC00001, 6'h1);
        run(SFPX_OP_MUL, 1'h0, 1'h0, 128'h7FC00002, 128'h7F800001, 12'h0, 128'h7FC00002, 6'h1);
        run(SFPX_OP_ADD, 1'h0, 1'h0, 128'h7F800000, 128'hFF800000, 12'h0, `SFPX_QNAN_SP, 6'h1);
        run(SFPX_OP_MUL, 1'h1, 1'h0, 128'h7FF0000000000000, 128'h0, 12'h0, `SFPX_QNAN_DP, 6'h1);
        run(SFPX_OP_SQRT, 1'h0, 1'h0, 128'hBF800000, 128'h0, 12'h0, `SFPX_QNAN_SP, 6'h1);
        run(SFPX_OP_CVTI, 1'h0, 1'h0, 128'h7FC00000, 128'h0, 12'h0, `SFPX_INT_INDEF, 6'h1);
        // Out-of-range conversion of a finite value
        sfpx_pipe_model_i.send(SFPX_OP_CVTI, 1'h0, 1'h0, 128'h4F000000, 128'h0, 12'h0, 4'h1);
        chk({rsp.res_valid, rsp.exc_valid}, 2'h2);
        chk(rsp.res, `SFPX_INT_INDEF);
        chk(rsp.flags, 6'h1);
        run(SFPX_OP_DIV, 1'h0, 1'h0, 128'h3F800000, 128'h0, 12'h0, 128'h3F800000, 6'h2);
        run(SFPX_OP_ADD, 1'h0, 1'h0, 128'h1, 128'h3F800000, 12'h0, 128'h3F800001, 6'h4);
        run(SFPX_OP_ADD, 1'h0, 1'h1, {4{32'h3F800000}}, 128'h0, 12'h420,
            {4{32'h3F800000}}, 6'h30);
        run(SFPX_OP_ADD, 1'h1, 1'h1, {64'h7FF0000000000001, 64'h3FF0000000000000}, 128'h0, 12'h0,
            {64'h7FF8000000000001, 64'h3FF0000000000000}, 6'h1);
    endtask

    task automatic t_unmask();
        // Clears the sticky flags too, so the final read is predictable
        apb(1'h1, `SFPX_OFF_CSR, 32'h00003E3F);
        apb(1'h1, `SFPX_OFF_IRQ_EN, 32'h00000003);
        last = rsp.res;
        sfpx_pipe_model_i.send(SFPX_OP_ADD, 1'h0, 1'h0, 128'h7F800001, 128'h5, 12'h0, 4'h0);
        chk({rsp.exc_valid, rsp.res_valid, rsp.fault, rsp.trap}, 4'hA);
        chk(rsp.res, last);
        chk(rsp.src1, 128'h7F800001);
        chk(rsp.src2, 128'h5);
        chk(irq, 1'h1);
        apb(1'h1, `SFPX_OFF_IRQ_STS, 32'h00000001);
        #1;
        chk(irq, 1'h0);
        run(SFPX_OP_ADD, 1'h0, 1'h0, 128'h7FC00001, 128'h5, 12'h0, 128'h7FC00001, 6'h0);
        apb(1'h1, `SFPX_OFF_CSR, 32'h00003700);
        sfpx_pipe_model_i.send(SFPX_OP_ADD, 1'h0, 1'h1, 128'h0, 128'h0, 12'h040, 4'h0);
        chk({rsp.exc_valid, rsp.res_valid, rsp.fault, rsp.trap}, 4'h9);
        chk({rsp.flags, irq}, {6'h08, 1'h1});
        apb(1'h0, `SFPX_OFF_CSR, 32'h0);
        chk(rd, 32'h00003709);
        // Element 2 overflow, trap kind, add op
        apb(1'h0, `SFPX_OFF_EXC_INFO, 32'h0);
        chk(rd, 32'h00000024);
        apb(1'h0, `SFPX_OFF_IRQ_STS, 32'h0);
        chk(rd, 32'h00000002);
    endtask

    initial begin
        error_cnt = 0;
        samples_checked = 0;
        apb_q = '0;
        rst_n = 1'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        t_reset();
        t_masked();
        t_unmask();
        test_done();
    end
endmodule

`default_nettype wire
